// ==== src/cmp_ctrl_params.svh ====
// offsets, field positions, field codes, reset values and response codes for the comparator control block
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register
// How it works
// - sense 00 any toggle, 10 falling, 11 rising, 01 reserved
// - capture enable routes comparator 1 output into timer 1 capture front end
// - comparator 1 capture interrupt only when timer capture mask bit set
// - capture edge select one takes rising edge, zero takes falling edge
// - capture enable clear leaves comparator 1 no path into capture logic
// - three-bit negative input select: fractions, bandgap, DAC, pin; 111 reserved
// - control bit 7 enables the comparator
// - control bit 6 gates the comparator interrupt request
// - bit 3 of comparator 2 and 3 control reads zero
// - status: flags in bits 7..4, live outputs in bits 3..0
// - hardware sets a flag on the selected output event
// - vector acknowledge clears a flag only when its interrupt enable is set
// - writing one clears a flag, writing zero leaves it
// - each flag is offered as a conversion trigger
// - live output bits show the current comparator output
// - comparator samples on every or every second clock, per halve bit
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH

`define OFS_CMP0_CTRL   5'h00
`define OFS_CMP1_CTRL   5'h04
`define OFS_CMP2_CTRL   5'h08
`define OFS_CMP3_CTRL   5'h0C
`define OFS_STATUS      5'h10
`define OFS_MASK        5'h14
`define OFS_MISC        5'h18

`define BIT_EN          7
`define BIT_IE          6
`define BIT_SENSE_HI    5
`define BIT_SENSE_LO    4
`define BIT_CAPT        3
`define BIT_SEL_HI      2
`define BIT_SEL_LO      0
`define BIT_MISC_HALVE  0

`define SENSE_TOGGLE    2'h0
`define SENSE_RSVD      2'h1
`define SENSE_FALL      2'h2
`define SENSE_RISE      2'h3
`define SEL_RSVD        3'h7

`define CTRL_RESET      8'h00
`define STATUS_RESET    8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== src/cmp_ctrl_pkg.sv ====
// types shared by the comparator control block
// assumes cmp_ctrl_params.svh supplies the numeric constants
package cmp_ctrl_pkg;
	typedef struct packed {
		logic       enable;
		logic       irq_enable;
		logic [1:0] irq_sense;
		logic       aux;
		logic [2:0] neg_input_sel;
	} cmp_ctrl_t;

	typedef struct packed {
		logic       capture_route_en;
		logic       timer1_capture_edge_sel;
		logic       timer1_capture_irq_mask;
	} capture_cfg_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_RESP = 2'b01
	} rd_state_t;
endpackage

// ==== src/analog_comparator_ctrl_flags.sv ====
// comparator control registers, event flags, interrupt and capture routing
// assumes comparator outputs and timer capture settings are synchronous to aclk
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "cmp_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_ctrl_flags
	import cmp_ctrl_pkg::*;
#(
	parameter int N_CMP = 4
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [3:0]  cmp_raw_out,
	input  wire logic [3:0]  irq_vector_ack,
	input  wire logic        timer1_capture_edge_sel,
	input  wire logic        timer1_capture_irq_mask,
	input  wire logic        capture_pin,
	output logic [3:0]       cmp_enable,
	output logic [11:0]      cmp_neg_input_sel,
	output logic [3:0]       cmp_sample_strobe,
	output logic [3:0]       cmp_irq_req,
	output logic [3:0]       conv_trigger,
	output logic             capture_src,
	output logic             capture_event,
	output logic             capture_irq,
	output logic             irq
);

	// the register map and status layout are fixed at four comparators
	if (N_CMP != 4) begin : g_bad_count
		$error("block serves exactly four comparators");
	end

	cmp_ctrl_t    ctrl_r [4];
	logic [3:0]   flag_r;
	logic [3:0]   mask_r;
	logic [3:0]   live_r;
	logic [3:0]   prev_r;
	logic         halve_r;
	logic         div_r;
	logic         sample_en;
	logic [3:0]   event_hit;
	logic [3:0]   flag_nxt;
	logic [3:0]   clr_wr;
	logic         cap_prev_r;
	capture_cfg_t cap_cfg;
	logic         wr_fire;
	logic         aw_held_r;
	logic         w_held_r;
	logic [4:0]   awaddr_r;
	logic [31:0]  wdata_r;
	logic [3:0]   wstrb_r;
	logic [4:0]   wr_addr;
	logic [31:0]  wr_data;
	logic         wr_lane0;
	rd_state_t    rd_state_r;
	logic [2:0]   rd_idx;

	// binary index of a control register, 4 when the address is not one
	function automatic logic [2:0] ctrl_index(input logic [4:0] addr);
		case (addr)
			5'(`OFS_CMP0_CTRL): ctrl_index = 3'h0;
			5'(`OFS_CMP1_CTRL): ctrl_index = 3'h1;
			5'(`OFS_CMP2_CTRL): ctrl_index = 3'h2;
			5'(`OFS_CMP3_CTRL): ctrl_index = 3'h3;
			default:            ctrl_index = 3'h4;
		endcase
	endfunction

	function automatic logic mapped(input logic [4:0] addr);
		mapped = (ctrl_index(addr) != 3'h4) || addr == `OFS_STATUS
			|| addr == `OFS_MASK || addr == `OFS_MISC;
	endfunction

	// the sample enable is the clock-divide strobe; with halve set only every second cycle samples
	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_r <= 1'b0;
		else
			div_r <= ~div_r;
	end
	assign sample_en = !halve_r || div_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			live_r <= 4'h0;
			prev_r <= 4'h0;
		end else if (sample_en) begin
			live_r <= cmp_raw_out;
			prev_r <= live_r;
		end
	end

	// event decode per comparator; sampled one cycle after live_r updates
	logic sample_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sample_d_r <= 1'b0;
		else
			sample_d_r <= sample_en;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_evt
			always_comb begin
				event_hit[gi] = 1'b0;
				if (sample_d_r && ctrl_r[gi].enable) begin
					case (ctrl_r[gi].irq_sense)
						`SENSE_TOGGLE: event_hit[gi] = live_r[gi] ^ prev_r[gi];
						`SENSE_FALL:   event_hit[gi] = prev_r[gi] & ~live_r[gi];
						`SENSE_RISE:   event_hit[gi] = ~prev_r[gi] & live_r[gi];
						default:       event_hit[gi] = 1'b0;
					endcase
				end
			end
			// vector ack only clears when the interrupt enable is set
			always_comb begin
				clr_wr[gi] = wr_fire && wr_addr == `OFS_STATUS && wr_lane0
					&& wr_data[`BIT_SENSE_LO + gi];
				flag_nxt[gi] = flag_r[gi];
				if (clr_wr[gi] || (irq_vector_ack[gi] && ctrl_r[gi].irq_enable))
					flag_nxt[gi] = 1'b0;
				if (event_hit[gi])
					flag_nxt[gi] = 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn)
			flag_r <= 4'h0;
		else
			flag_r <= flag_nxt;
	end

	// AXI write path: address and data accepted independently
	assign wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
	assign wr_data  = w_held_r ? wdata_r : s_axi_wdata;
	assign wr_lane0 = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];
	assign wr_fire  = (aw_held_r || (s_axi_awvalid && s_axi_awready))
		&& (w_held_r || (s_axi_wvalid && s_axi_wready));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 5'h00;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !s_axi_bvalid && !aw_held_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !s_axi_bvalid && !w_held_r && !(s_axi_wvalid && s_axi_wready);
			if (wr_fire) begin
				aw_held_r     <= 1'b0;
				w_held_r      <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_r <= 1'b1;
					awaddr_r  <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_r <= 1'b1;
					wdata_r  <= s_axi_wdata;
					wstrb_r  <= s_axi_wstrb;
				end
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// control registers; reserved bit 3 of comparators 2 and 3 is never stored
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ctrl
			always_ff @(posedge aclk) begin
				if (!aresetn)
					ctrl_r[gi] <= `CTRL_RESET;
				else if (wr_fire && wr_lane0 && ctrl_index(wr_addr) == 3'(gi)) begin
					ctrl_r[gi] <= wr_data[7:0];
					if (gi >= 2)
						ctrl_r[gi].aux <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r  <= 4'h0;
			halve_r <= 1'b0;
		end else if (wr_fire && wr_lane0) begin
			if (wr_addr == `OFS_MASK)
				mask_r <= wr_data[3:0];
			if (wr_addr == `OFS_MISC)
				halve_r <= wr_data[`BIT_MISC_HALVE];
		end
	end

	// a function result cannot be part-selected directly, so the index gets its own net
	assign rd_idx = ctrl_index(s_axi_araddr);

	// AXI read path: one outstanding read, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r    <= RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			case (rd_state_r)
				RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
						s_axi_rdata   <= 32'h00000000;
						if (rd_idx != 3'h4)
							s_axi_rdata[7:0] <= ctrl_r[rd_idx[1:0]];
						else if (s_axi_araddr == `OFS_STATUS)
							s_axi_rdata[7:0] <= {flag_r, live_r};
						else if (s_axi_araddr == `OFS_MASK)
							s_axi_rdata[3:0] <= mask_r;
						else if (s_axi_araddr == `OFS_MISC)
							s_axi_rdata[0] <= halve_r;
						rd_state_r <= RD_RESP;
					end
				end
				RD_RESP: begin
					s_axi_arready <= 1'b0;
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_r   <= RD_IDLE;
					end
				end
				default: rd_state_r <= RD_IDLE;
			endcase
		end
	end

	// capture routing from comparator 1
	assign cap_cfg = '{ctrl_r[1].aux, timer1_capture_edge_sel, timer1_capture_irq_mask};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_src   <= 1'b0;
			cap_prev_r    <= 1'b0;
			capture_event <= 1'b0;
			capture_irq   <= 1'b0;
		end else begin
			// with routing off the comparator has no path, the pin is used instead
			capture_src <= cap_cfg.capture_route_en ? live_r[1] : capture_pin;
			cap_prev_r  <= capture_src;
			capture_event <= cap_cfg.timer1_capture_edge_sel ? (capture_src & ~cap_prev_r)
				: (~capture_src & cap_prev_r);
			capture_irq <= capture_event && cap_cfg.timer1_capture_irq_mask;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_enable        <= 4'h0;
			cmp_neg_input_sel <= 12'h000;
			cmp_sample_strobe <= 4'h0;
			cmp_irq_req       <= 4'h0;
			conv_trigger      <= 4'h0;
			irq               <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				cmp_enable[i]             <= ctrl_r[i].enable;
				cmp_neg_input_sel[i*3 +: 3] <= ctrl_r[i].neg_input_sel;
				cmp_sample_strobe[i]      <= sample_en && ctrl_r[i].enable;
				cmp_irq_req[i]            <= flag_nxt[i] && ctrl_r[i].irq_enable;
			end
			conv_trigger <= flag_nxt;
			irq          <= |(flag_nxt & mask_r);
		end
	end

endmodule
`default_nettype wire

// ==== verif/cmp_far_model.sv ====
// far-side model: four clocked comparators answering the block's sample strobes
// assumes the bench presents each comparison outcome on level
`timescale 1ns/10ps
`default_nettype none
module cmp_far_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] level,
	input  wire logic [3:0] cmp_enable,
	input  wire logic [3:0] cmp_sample_strobe,
	output logic [3:0]      cmp_raw_out
);
	logic [3:0] take;
	assign take = cmp_enable & cmp_sample_strobe;
	// a disabled comparator holds its last result rather than following its input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_raw_out <= 4'h0;
		end else begin
			cmp_raw_out <= (cmp_raw_out & ~take) | (level & take);
		end
	end
endmodule
`default_nettype wire

// ==== verif/cmp_ctrl_checker.sv ====
// checker: bus handshakes, flag, interrupt and capture relations
// assumes it is bound to analog_comparator_ctrl_flags
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0]  conv_trigger,
	input wire logic [3:0]  cmp_irq_req,
	input wire logic        irq,
	input wire logic        capture_event,
	input wire logic        timer1_capture_irq_mask,
	input wire logic        capture_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_reset_quiet; $rose(aresetn) |-> !irq && conv_trigger == 4'h0; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_b_next; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
	a_b_next: assert property (p_b_next) else $error("write response late");
	property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_next: assert property (p_r_next) else $error("read response late");
	property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_req_flag; (cmp_irq_req & ~conv_trigger) == 4'h0; endproperty
	a_req_flag: assert property (p_req_flag) else $error("request without flag");
	property p_irq_flag; irq |-> conv_trigger != 4'h0; endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("interrupt without flag");
	property p_cap_fwd; capture_event && timer1_capture_irq_mask |=> capture_irq; endproperty
	a_cap_fwd: assert property (p_cap_fwd) else $error("capture interrupt missing");
	property p_cap_back; capture_irq |-> $past(capture_event) && $past(timer1_capture_irq_mask); endproperty
	a_cap_back: assert property (p_cap_back) else $error("capture interrupt unmasked");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_cap_irq: cover property (capture_irq);
	c_irq_no_req: cover property (irq && cmp_irq_req == 4'h0);
endmodule
bind analog_comparator_ctrl_flags cmp_ctrl_checker cmp_ctrl_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .conv_trigger, .cmp_irq_req, .irq, .capture_event,
	.timer1_capture_irq_mask, .capture_irq);
`default_nettype wire

// ==== verif/testbench.sv ====
// bench: register table, flag events, interrupt and capture routing
// assumes the comparator far-side model and the checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
	typedef struct packed {logic [4:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_t;
	logic        aclk = 1'h0, aresetn = 1'h0, capture_pin = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, timer1_capture_edge_sel = 1'h0, timer1_capture_irq_mask = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        capture_src, capture_event, capture_irq, irq;
	logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb = 4'hF, irq_vector_ack = 4'h0, level = 4'h0;
	logic [3:0]  cmp_raw_out, cmp_enable, cmp_sample_strobe, cmp_irq_req, conv_trigger;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_seen;
	logic [11:0] cmp_neg_input_sel;
	int          bad_count = 0, total_checks = 0, ev_cnt = 0, irq_cnt = 0, e0, i0;
	row_t        rows[6] = '{'{5'h00, 8'hA5, 8'hA5, 2'h0}, '{5'h04, 8'hFF, 8'hFF, 2'h0},
		'{5'h08, 8'hFF, 8'hF7, 2'h0}, '{5'h0C, 8'hFF, 8'hF7, 2'h0}, '{5'h10, 8'hFF, 8'h00, 2'h0},
		'{5'h1C, 8'h5A, 8'h00, 2'h2}};
	logic [1:0]  senses[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	analog_comparator_ctrl_flags analog_comparator_ctrl_flags_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cmp_raw_out, .irq_vector_ack, .timer1_capture_edge_sel,
		.timer1_capture_irq_mask, .capture_pin, .cmp_enable, .cmp_neg_input_sel, .cmp_sample_strobe,
		.cmp_irq_req, .conv_trigger, .capture_src, .capture_event, .capture_irq, .irq);
	cmp_far_model cmp_far_model_inst (.aclk, .aresetn, .level, .cmp_enable, .cmp_sample_strobe, .cmp_raw_out);
	initial begin
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		ev_cnt += capture_event;
		irq_cnt += capture_irq;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// both write channels are offered together; each drops as soon as it is taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (!s_axi_bvalid);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		s_axi_rready <= 1'h0;
	endtask
	task automatic ack2();
		irq_vector_ack <= 4'h4;
		wt(1);
		irq_vector_ack <= 4'h0;
		wt(2);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		wt(20000);
		bad_count++;
		wrap_up();
	end
	initial begin
		wt(8);
		aresetn <= 1'h1;
		wt(1);
		for (int k = 2; k < 5; k++) begin
			rd(5'(k * 4));
			`CHK("reset value", 32'h0, rdat)
		end
		$display("test reset done");
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			`CHK("bresp", rows[k].r, bresp_seen)
			rd(rows[k].a);
			`CHK("rdata", {24'h0, rows[k].e}, rdat)
		end
		for (int c = 0; c < 7; c++) begin
			wr(5'h0C, 8'(c));
			wt(1);
			`CHK("neg select", 3'(c), cmp_neg_input_sel[11:9])
			`CHK("enable off", 1'h0, cmp_enable[3])
		end
		$display("test registers done");
		wr(5'h14, 8'h0F);
		foreach (senses[k]) begin
			wr(5'h08, {2'h3, senses[k], 4'h0});
			wr(5'h10, 8'hF0);
			level[2] <= 1'h1;
			wt(8);
			rd(5'h10);
			`CHK("rise flag", 1'(senses[k] == 2'h0 || senses[k] == 2'h3), rdat[6])
			`CHK("live bit", 1'h1, rdat[2])
			wr(5'h10, 8'h40);
			level[2] <= 1'h0;
			wt(8);
			`CHK("fall flag", 1'(senses[k] == 2'h0 || senses[k] == 2'h2), conv_trigger[2])
			`CHK("irq", 1'(senses[k] == 2'h0 || senses[k] == 2'h2), irq)
		end
		wr(5'h08, 8'h80);
		level[2] <= 1'h1;
		wt(8);
		wr(5'h10, 8'h00);
		ack2();
		`CHK("flag kept", 1'h1, conv_trigger[2])
		`CHK("request gated", 1'h0, cmp_irq_req[2])
		wr(5'h14, 8'h00);
		wt(1);
		`CHK("irq masked", 1'h0, irq)
		wr(5'h08, 8'hC0);
		wt(1);
		`CHK("request on", 1'h1, cmp_irq_req[2])
		ack2();
		`CHK("flag taken", 1'h0, conv_trigger[2])
		wr(5'h08, 8'h00);
		level[2] <= 1'h0;
		wt(8);
		`CHK("disabled", 1'h0, conv_trigger[2])
		$display("test flags done");
		wr(5'h18, 8'h01);
		timer1_capture_edge_sel <= 1'h1;
		timer1_capture_irq_mask <= 1'h1;
		wr(5'h04, 8'h88);
		e0 = ev_cnt;
		i0 = irq_cnt;
		level[1] <= 1'h1;
		wt(10);
		`CHK("routed source", 1'h1, capture_src)
		`CHK("enable on", 1'h1, cmp_enable[1])
		level[1] <= 1'h0;
		wt(10);
		`CHK("rising only", e0 + 1, ev_cnt)
		timer1_capture_edge_sel <= 1'h0;
		timer1_capture_irq_mask <= 1'h0;
		level[1] <= 1'h1;
		wt(10);
		level[1] <= 1'h0;
		wt(10);
		`CHK("falling event", e0 + 2, ev_cnt)
		`CHK("capture irq", i0 + 1, irq_cnt)
		wr(5'h04, 8'h80);
		capture_pin <= 1'h1;
		level[1] <= 1'h1;
		wt(10);
		`CHK("pin source", 1'h1, capture_src)
		capture_pin <= 1'h0;
		wt(10);
		`CHK("no comparator path", 1'h0, capture_src)
		$display("test capture done");
		wrap_up();
	end
endmodule
`default_nettype wire
